//--- logic/mlf_pkg.sv
// constants, types and helpers for the motor-lock fault response block
package mlf_pkg;

  // clock and retry timing
  localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
  localparam int unsigned RETRY_UNIT_MS   = 500;
  localparam int unsigned HALF_SEC_CYCLES = RETRY_UNIT_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned HALVES_W        = 5;
  localparam int unsigned PRESCALE_W      = 32;

  // register offsets (byte addresses on the register port)
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  OFS_CFG1     = 8'h00;
  localparam logic [7:0]  OFS_CTRL     = 8'h04;
  localparam logic [7:0]  OFS_STAT     = 8'h08;
  localparam logic [7:0]  OFS_INT_STAT = 8'h0C;
  localparam logic [7:0]  OFS_INT_MASK = 8'h10;

  // field positions
  localparam int unsigned CFG_INTERVAL_LSB = 7;
  localparam int unsigned CFG_MODE_LSB     = 3;
  localparam int unsigned CTRL_LIMIT_LSB   = 0;
  localparam int unsigned CTRL_CLEAR_BIT   = 8;
  localparam int unsigned STAT_STATE_LSB   = 0;
  localparam int unsigned STAT_COUNT_LSB   = 2;
  localparam int unsigned STAT_GATE_LSB    = 5;
  localparam int unsigned LIMIT_W          = 3;

  // reset values
  localparam logic [3:0]         INTERVAL_RST = 4'h0;
  localparam logic [3:0]         MODE_RST     = 4'h0;
  localparam logic [LIMIT_W-1:0] LIMIT_RST    = 3'h0;
  localparam logic [2:0]         MASK_RST     = 3'h0;

  // lock response mode codes
  localparam logic [3:0] MODE_AUTO_MIN    = 4'h4;
  localparam logic [3:0] MODE_REPORT      = 4'h8;
  localparam logic [3:0] MODE_DISABLE_MIN = 4'h9;

  // interrupt bits
  localparam int unsigned INT_W       = 3;
  localparam int unsigned INT_FAULT   = 0;
  localparam int unsigned INT_AUTOCLR = 1;
  localparam int unsigned INT_LATCH   = 2;

  typedef enum logic [2:0] {
    GATE_DRIVE  = 3'h0,
    GATE_TRI    = 3'h1,
    GATE_RECIRC = 3'h3,
    GATE_HS     = 3'h2,
    GATE_LS     = 3'h6
  } mlf_gate_e;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_RETRY   = 2'h1,
    ST_LATCHED = 2'h3,
    ST_REPORT  = 2'h2
  } mlf_state_e;

  // retry interval in half seconds; reserved code 0 runs as code 1
  function automatic logic [HALVES_W-1:0] mlf_retry_halves(input logic [3:0] code);
    logic [HALVES_W-1:0] h;
    h = 5'h01;
    if (code > 4'h1) begin
      h = {code, 1'b0} - 5'h02;
    end
    return h;
  endfunction

  // gate state selected by the low two bits of the mode
  function automatic mlf_gate_e mlf_gate_for(input logic [3:0] mode);
    mlf_gate_e g;
    g = GATE_TRI;
    unique case (mode[1:0])
      2'h0: g = GATE_TRI;
      2'h1: g = GATE_RECIRC;
      2'h2: g = GATE_HS;
      2'h3: g = GATE_LS;
    endcase
    return g;
  endfunction

endpackage

//--- logic/mlf_retry_timer.sv
// retry interval timer counting half-second steps
`timescale 1ns/1ns
module mlf_retry_timer #(
  parameter int unsigned HALF_SEC_CYCLES = mlf_pkg::HALF_SEC_CYCLES
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  reset,
  // control side
  mlf_timer_if.timer tmr
);
  import mlf_pkg::*;

  logic                  running;
  logic [PRESCALE_W-1:0] prescale;
  logic [HALVES_W-1:0]   remain;
  logic                  expired;
  logic                  next_running;
  logic [PRESCALE_W-1:0] next_prescale;
  logic [HALVES_W-1:0]   next_remain;
  logic                  next_expired;

  assign tmr.expired = expired;

  // a new start always restarts the interval from zero
  always_comb begin
    next_running  = running;
    next_prescale = prescale;
    next_remain   = remain;
    next_expired  = 1'b0;
    if (tmr.start) begin
      next_running  = 1'b1;
      next_prescale = PRESCALE_W'(HALF_SEC_CYCLES - 1);
      next_remain   = tmr.halves;
    end else if (running) begin
      if (prescale != '0) begin
        next_prescale = prescale - 1'b1;
      end else if (remain <= 5'h01) begin
        next_running = 1'b0;
        next_expired = 1'b1;
      end else begin
        next_remain   = remain - 1'b1;
        next_prescale = PRESCALE_W'(HALF_SEC_CYCLES - 1);
      end
    end
  end

  // timer state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      running  <= 1'b0;
      prescale <= '0;
      remain   <= '0;
      expired  <= 1'b0;
    end else begin
      running  <= next_running;
      prescale <= next_prescale;
      remain   <= next_remain;
      expired  <= next_expired;
    end
  end

endmodule

//--- logic/mlf_timer_if.sv
// start and expiry handshake between fault control and retry timer
`timescale 1ns/1ns
interface mlf_timer_if;
  logic                         start;
  logic [mlf_pkg::HALVES_W-1:0] halves;
  logic                         expired;

  modport ctrl  (output start, output halves, input expired);
  modport timer (input start, input halves, output expired);
endinterface

//--- logic/mlf_top.sv
// motor-lock fault response: mode decode, retry, gate state and registers
//
// Notes on behaviour
// - retry interval code 1 is 500 ms, code n>=2 is n-1 seconds; 0 reserved.
// - modes 0 to 3 latch the fault and hold the fault pin active.
// - modes 0 and 4 tristate every gate driver output during the fault.
// - modes 1 and 5 put the gate driver into recirculation during the fault.
// - modes 2/6 brake on all high sides, modes 3/7 on all low sides.
// - modes 4, 5, 7 auto-clear after the interval; pin active meanwhile.
// - retry modes count retries; past the limit the fault latches, gate state kept.
// - mode 6 auto-clears up to the limit, braking high side, pin active.
// - mode 8 only reports on the fault pin; gate driver untouched.
// - modes 9 and above ignore a lock completely.
`timescale 1ns/1ns
module mlf_top #(
  parameter int unsigned HALF_SEC_CYCLES = mlf_pkg::HALF_SEC_CYCLES
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // lock detector, same clock domain
  input  wire logic                        lock_detect,
  // register port
  input  wire logic [mlf_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output logic      [31:0]                 reg_rdata,
  // gate driver and pins
  output mlf_pkg::mlf_gate_e               gate_state,
  output logic                             fault_indicator_pin_n,
  output logic                             irq
);
  import mlf_pkg::*;

  mlf_timer_if tmr ();

  logic [3:0]         lock_retry_interval;
  logic [3:0]         lock_response_mode;
  logic [LIMIT_W-1:0] retry_count_limit;
  logic [INT_W-1:0]   int_mask;
  logic [INT_W-1:0]   int_stat;
  logic [3:0]         next_interval;
  logic [3:0]         next_mode;
  logic [LIMIT_W-1:0] next_limit;
  logic [INT_W-1:0]   next_mask;
  logic [INT_W-1:0]   next_int_stat;
  logic [31:0]        next_rdata;
  logic               next_irq;
  logic               clear_req;

  mlf_state_e         state;
  mlf_state_e         next_state;
  mlf_gate_e          next_gate;
  logic [LIMIT_W-1:0] retry_cnt;
  logic [LIMIT_W-1:0] next_retry_cnt;
  logic               next_pin_n;
  logic               start;
  logic [INT_W-1:0]   ev;

  // decoded lock conditions
  logic lock_idle;
  logic mode_auto;
  logic mode_off;

  assign lock_idle = (state == ST_IDLE) && lock_detect;
  assign mode_auto = (lock_response_mode >= MODE_AUTO_MIN) && (lock_response_mode < MODE_REPORT);
  assign mode_off  = (lock_response_mode >= MODE_DISABLE_MIN);
  assign clear_req = reg_write && (reg_addr == OFS_CTRL) && reg_wdata[CTRL_CLEAR_BIT];

  // timer request
  assign tmr.start  = start;
  assign tmr.halves = mlf_retry_halves(lock_retry_interval);

  mlf_retry_timer #(
    .HALF_SEC_CYCLES (HALF_SEC_CYCLES)
  ) u_timer (
    .clk   (clk),
    .reset (reset),
    .tmr   (tmr)
  );

  // fault state machine; gate state stays until the fault ends
  always_comb begin
    next_state     = state;
    next_gate      = gate_state;
    next_retry_cnt = retry_cnt;
    start          = 1'b0;
    ev             = '0;
    unique case (state)
      ST_IDLE: begin
        if (lock_detect && !mode_off) begin
          ev[INT_FAULT] = 1'b1;
          if (lock_response_mode == MODE_REPORT) begin
            next_state = ST_REPORT;
          end else if (!mode_auto) begin
            next_state = ST_LATCHED;
            next_gate  = mlf_gate_for(lock_response_mode);
          end else if (retry_cnt >= retry_count_limit) begin
            // retries used up: this lock would exceed the limit
            next_state     = ST_LATCHED;
            next_gate      = mlf_gate_for(lock_response_mode);
            ev[INT_LATCH]  = 1'b1;
          end else begin
            next_state = ST_RETRY;
            next_gate  = mlf_gate_for(lock_response_mode);
            start      = 1'b1;
          end
        end
      end
      ST_RETRY: begin
        if (clear_req) begin
          next_state     = ST_IDLE;
          next_gate      = GATE_DRIVE;
          next_retry_cnt = '0;
        end else if (tmr.expired) begin
          next_state       = ST_IDLE;
          next_gate        = GATE_DRIVE;
          next_retry_cnt   = retry_cnt + 1'b1;
          ev[INT_AUTOCLR]  = 1'b1;
        end
      end
      ST_LATCHED, ST_REPORT: begin
        // only software ends a latched or reported fault
        if (clear_req) begin
          next_state     = ST_IDLE;
          next_gate      = GATE_DRIVE;
          next_retry_cnt = '0;
        end
      end
    endcase
    next_pin_n = (next_state == ST_IDLE);
  end

  // fault state registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state                 <= ST_IDLE;
      gate_state            <= GATE_DRIVE;
      retry_cnt             <= '0;
      fault_indicator_pin_n <= 1'b1;
    end else begin
      state                 <= next_state;
      gate_state            <= next_gate;
      retry_cnt             <= next_retry_cnt;
      fault_indicator_pin_n <= next_pin_n;
    end
  end

  // register writes, sticky status and read data
  always_comb begin
    next_interval = lock_retry_interval;
    next_mode     = lock_response_mode;
    next_limit    = retry_count_limit;
    next_mask     = int_mask;
    next_int_stat = int_stat;
    next_rdata    = 32'h0000_0000;
    if (reg_write) begin
      unique case (reg_addr)
        OFS_CFG1: begin
          next_interval = reg_wdata[CFG_INTERVAL_LSB +: 4];
          next_mode     = reg_wdata[CFG_MODE_LSB +: 4];
        end
        OFS_CTRL:     next_limit = reg_wdata[CTRL_LIMIT_LSB +: LIMIT_W];
        OFS_INT_MASK: next_mask = reg_wdata[INT_W-1:0];
        OFS_INT_STAT: next_int_stat = int_stat & ~reg_wdata[INT_W-1:0];
        default:      next_mask = int_mask;
      endcase
    end
    // a new event beats a clear in the same cycle
    next_int_stat = next_int_stat | ev;
    if (reg_read) begin
      unique case (reg_addr)
        OFS_CFG1: begin
          next_rdata[CFG_INTERVAL_LSB +: 4] = lock_retry_interval;
          next_rdata[CFG_MODE_LSB +: 4]     = lock_response_mode;
        end
        OFS_CTRL:     next_rdata[CTRL_LIMIT_LSB +: LIMIT_W] = retry_count_limit;
        OFS_STAT: begin
          next_rdata[STAT_STATE_LSB +: 2]       = state;
          next_rdata[STAT_COUNT_LSB +: LIMIT_W] = retry_cnt;
          next_rdata[STAT_GATE_LSB +: 3]        = gate_state;
        end
        OFS_INT_STAT: next_rdata[INT_W-1:0] = int_stat;
        OFS_INT_MASK: next_rdata[INT_W-1:0] = int_mask;
        default:      next_rdata = 32'h0000_0000;
      endcase
    end
    next_irq = |(next_int_stat & next_mask);
  end

  // register file
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_retry_interval <= INTERVAL_RST;
      lock_response_mode  <= MODE_RST;
      retry_count_limit   <= LIMIT_RST;
      int_mask            <= MASK_RST;
      int_stat            <= '0;
      reg_rdata           <= 32'h0000_0000;
      irq                 <= 1'b0;
    end else begin
      lock_retry_interval <= next_interval;
      lock_response_mode  <= next_mode;
      retry_count_limit   <= next_limit;
      int_mask            <= next_mask;
      int_stat            <= next_int_stat;
      reg_rdata           <= next_rdata;
      irq                 <= next_irq;
    end
  end

  // checks on the fault response
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_interval_decode: assert property (
    start |-> (tmr.halves == ((lock_retry_interval <= 4'h1) ? 5'h01 : {lock_retry_interval, 1'b0} - 5'h02)))
    else $error("retry interval decode wrong");

  a_latched_pin: assert property (
    (lock_idle && lock_response_mode <= 4'h3) |=> (state == ST_LATCHED && !fault_indicator_pin_n))
    else $error("latched fault not raised");

  a_tristate_gate: assert property (
    (lock_idle && (lock_response_mode == 4'h0 || lock_response_mode == 4'h4)) |=> gate_state == GATE_TRI)
    else $error("gate not tristated");

  a_recirc_gate: assert property (
    (lock_idle && (lock_response_mode == 4'h1 || lock_response_mode == 4'h5)) |=> gate_state == GATE_RECIRC)
    else $error("gate not in recirculation");

  a_brake_gate: assert property (
    (lock_idle && (lock_response_mode == 4'h3 || lock_response_mode == 4'h7)) |=> gate_state == GATE_LS)
    else $error("low side brake missing");

  a_auto_clear: assert property (
    (state == ST_RETRY && tmr.expired && !clear_req) |=> (state == ST_IDLE && fault_indicator_pin_n
      && gate_state == GATE_DRIVE && retry_cnt == $past(retry_cnt) + 3'h1))
    else $error("auto clear did not release fault");

  a_retry_limit: assert property (
    (lock_idle && mode_auto && retry_cnt >= retry_count_limit) |=> (state == ST_LATCHED && int_stat[INT_LATCH])
    ##1 (state == ST_LATCHED || $past(clear_req)))
    else $error("fault not latched past retry limit");

  a_mode6_retry: assert property (
    (lock_idle && lock_response_mode == 4'h6 && retry_cnt < retry_count_limit)
      |=> (state == ST_RETRY && gate_state == GATE_HS && !fault_indicator_pin_n))
    else $error("mode 6 retry behaviour wrong");

  a_report_only: assert property (
    (lock_idle && lock_response_mode == MODE_REPORT) |=> (!fault_indicator_pin_n && gate_state == GATE_DRIVE))
    else $error("report mode touched gate or missed pin");

  a_lock_disabled: assert property (
    (lock_idle && mode_off) |=> (state == ST_IDLE && fault_indicator_pin_n
      && (int_stat & ~$past(int_stat)) == 3'h0))
    else $error("disabled lock raised a fault");

  a_latch_holds: assert property (
    (state == ST_LATCHED && !clear_req) |=> (state == ST_LATCHED && !fault_indicator_pin_n
      && $stable(gate_state)))
    else $error("latched fault released without clear");

  a_high_brake: assert property (
    (lock_idle && (lock_response_mode == 4'h2 || lock_response_mode == 4'h6)) |=> gate_state == GATE_HS)
    else $error("high side brake missing");

  a_fault_event: assert property (
    (lock_idle && !mode_off) |=> (int_stat[INT_FAULT] && !fault_indicator_pin_n))
    else $error("lock did not raise a fault");

  a_retry_holds: assert property (
    (state == ST_RETRY && !tmr.expired && !clear_req) |=> (state == ST_RETRY && !fault_indicator_pin_n
      && $stable(gate_state) && $stable(retry_cnt)))
    else $error("retry fault changed before expiry");

  a_busy_no_count: assert property (
    ((state == ST_LATCHED || state == ST_REPORT) && !clear_req) |=> $stable(retry_cnt))
    else $error("retry count moved during a held fault");

  a_clear_ends: assert property (
    (state != ST_IDLE && clear_req) |=> (state == ST_IDLE && fault_indicator_pin_n
      && gate_state == GATE_DRIVE && retry_cnt == 3'h0))
    else $error("clear did not end the fault");

  a_idle_drive: assert property (
    (state == ST_IDLE) |-> (fault_indicator_pin_n && gate_state == GATE_DRIVE))
    else $error("idle state with fault outputs active");

  // interrupt and register port checks; a clear racing an event must lose
  a_irq_level: assert property (
    irq == |(int_stat & int_mask))
    else $error("interrupt level does not follow status");

  a_status_sticky: assert property (
    (int_stat[INT_FAULT] && !(reg_write && reg_addr == OFS_INT_STAT && reg_wdata[INT_FAULT]))
      |=> int_stat[INT_FAULT])
    else $error("fault status bit lost without a clear");

  a_set_wins: assert property (
    ev[INT_FAULT] |=> int_stat[INT_FAULT])
    else $error("status clear beat a new fault event");

  a_rdata_idle: assert property (
    !reg_read |=> reg_rdata == 32'h0000_0000)
    else $error("read data stands outside its cycle");

endmodule

//--- testbench/motor_lock_fault_response_tb.sv
// self-checking bench for the motor-lock fault response block
`timescale 1ns/1ns
module motor_lock_fault_response_tb;
  import mlf_pkg::*;

  // short half-second count keeps the longest interval near 300 cycles
  localparam int unsigned HSC = 10;

  typedef struct packed {
    logic [31:0] data;
    logic [2:0]  gate;
    logic        pin_n;
    logic        irq;
  } mlf_note_s;

  logic              clk;
  logic              reset;
  logic              lock_detect;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_write;
  logic              reg_read;
  logic [31:0]       reg_rdata;
  mlf_gate_e         gate_state;
  logic              fault_indicator_pin_n;
  logic              irq;
  mlf_note_s         notes[$];
  mlf_note_s         note;
  logic              rd_d;
  mlf_gate_e         eg;
  logic              ep;
  logic              ei;
  logic [31:0]       seed;
  int                errors;
  int                check_count;
  int                cyc;
  mlf_gate_e         gt[4] = '{GATE_TRI, GATE_RECIRC, GATE_HS, GATE_LS};

  mlf_top #(.HALF_SEC_CYCLES(HSC)) dut (
    .clk                   (clk),
    .reset                 (reset),
    .lock_detect           (lock_detect),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_write             (reg_write),
    .reg_read              (reg_read),
    .reg_rdata             (reg_rdata),
    .gate_state            (gate_state),
    .fault_indicator_pin_n (fault_indicator_pin_n),
    .irq                   (irq)
  );

  always #5 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // status word from expected state, retry count and current gate note
  function automatic logic [31:0] st(input logic [1:0] s, input logic [2:0] c);
    return {24'h000000, eg, c, s};
  endfunction

  task automatic end_of_test();
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // the note also records the pin levels expected while the data stand
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    notes.push_back('{d, eg, ep, ei});
    @(posedge clk);
    reg_read <= 1'b0;
  endtask

  task automatic lock_pulse();
    @(posedge clk);
    lock_detect <= 1'b1;
    @(posedge clk);
    lock_detect <= 1'b0;
  endtask

  // cycles from lock to pin release, with a little slack for the handshake
  task automatic interval(input logic [3:0] code);
    int n;
    int h;
    h = (code <= 4'h1) ? 1 : 2 * code - 2;
    wr(OFS_CFG1, (32'(code) << CFG_INTERVAL_LSB) | (32'h4 << CFG_MODE_LSB));
    lock_pulse();
    n = 0;
    @(posedge clk);
    #1;
    while (fault_indicator_pin_n !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    check_count++;
    if (n < HSC * h - 2 || n > HSC * h + 4) begin
      errors++;
      $display("BAD %0t interval code %h took %0d cycles", $time, code, n);
    end
    wr(OFS_CTRL, 32'h107);
  endtask

  // monitor: the oldest note is due in the cycle after each read strobe
  always @(posedge clk) begin
    rd_d <= reg_read;
    if (rd_d === 1'b1) begin
      check_count++;
      if (notes.size() == 0) begin
        errors++;
        $display("BAD %0t read data with no expectation", $time);
      end else begin
        note = notes.pop_front();
        if (reg_rdata !== note.data || gate_state !== note.gate || fault_indicator_pin_n !== note.pin_n ||
            irq !== note.irq) begin
          errors++;
          $display("BAD %0t got %h %h %b %b want %h %h %b %b", $time, reg_rdata, gate_state,
                   fault_indicator_pin_n, irq, note.data, note.gate, note.pin_n, note.irq);
        end
      end
    end
  end

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      end_of_test();
    end
  end

  initial begin
    logic [31:0] v;
    clk = 0; reset = 1; lock_detect = 0; reg_addr = '0; reg_wdata = '0;
    reg_write = 0; reg_read = 0; rd_d = 0; seed = 32'h0000001B;
    errors = 0; check_count = 0; cyc = 0;
    eg = GATE_DRIVE; ep = 1'b1; ei = 1'b0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    // reset values, unmapped address last
    foreach (gt[i]) rd(8'(4 * i), 32'h0);
    rd(OFS_INT_MASK, 32'h0);
    rd(8'h14, 32'h0);
    // random config words read back through their field masks
    repeat (4) begin
      v = rnd();
      wr(OFS_CFG1, v);
      rd(OFS_CFG1, v & 32'h000007F8);
      wr(OFS_CTRL, v & 32'h000000FF);
      rd(OFS_CTRL, v & 32'h00000007);
    end
    // latching modes, held well past the code 1 retry interval
    for (int m = 0; m < 4; m++) begin
      wr(OFS_INT_MASK, 32'h1);
      wr(OFS_CFG1, (32'(m) << CFG_MODE_LSB) | 32'h80);
      lock_pulse();
      eg = gt[m]; ep = 0; ei = 1;
      repeat (30) @(posedge clk);
      rd(OFS_STAT, st(2'h3, 3'h0));
      wr(OFS_INT_STAT, 32'h1);
      ei = 0;
      rd(OFS_INT_STAT, 32'h0);
      wr(OFS_CTRL, 32'h100);
      eg = GATE_DRIVE; ep = 1;
      rd(OFS_STAT, 32'h0);
    end
    // retry modes, limit one: one auto-clear, then the next lock latches
    wr(OFS_INT_MASK, 32'h4);
    for (int m = 4; m < 8; m++) begin
      wr(OFS_CTRL, 32'h1);
      wr(OFS_CFG1, (32'(m) << CFG_MODE_LSB) | 32'h80);
      lock_pulse();
      eg = gt[m - 4]; ep = 0; ei = 0;
      rd(OFS_STAT, st(2'h1, 3'h0));
      repeat (3 * HSC) @(posedge clk);
      eg = GATE_DRIVE; ep = 1;
      rd(OFS_STAT, st(2'h0, 3'h1));
      rd(OFS_INT_STAT, 32'h3);
      lock_pulse();
      eg = gt[m - 4]; ep = 0; ei = 1;
      rd(OFS_STAT, st(2'h3, 3'h1));
      wr(OFS_CTRL, 32'h101);
      wr(OFS_INT_STAT, 32'h7);
      eg = GATE_DRIVE; ep = 1; ei = 0;
      rd(OFS_STAT, 32'h0);
    end
    // limit zero leaves no retry at all
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CFG1, (32'h7 << CFG_MODE_LSB) | 32'h80);
    lock_pulse();
    eg = GATE_LS; ep = 0; ei = 1;
    rd(OFS_STAT, st(2'h3, 3'h0));
    wr(OFS_CTRL, 32'h100);
    wr(OFS_INT_STAT, 32'h7);
    eg = GATE_DRIVE; ep = 1; ei = 0;
    // report only: pin active, gate untouched
    wr(OFS_CFG1, 32'h8 << CFG_MODE_LSB);
    lock_pulse();
    ep = 0;
    rd(OFS_STAT, st(2'h2, 3'h0));
    wr(OFS_CTRL, 32'h100);
    wr(OFS_INT_STAT, 32'h7);
    ep = 1;
    // a lock during a retry is ignored, and a clear aborts the retry
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CFG1, (32'h5 << CFG_MODE_LSB) | 32'h780);
    lock_pulse();
    eg = GATE_RECIRC; ep = 0;
    lock_pulse();
    rd(OFS_STAT, st(2'h1, 3'h0));
    wr(OFS_CTRL, 32'h101);
    wr(OFS_INT_STAT, 32'h7);
    eg = GATE_DRIVE; ep = 1;
    rd(OFS_STAT, 32'h0);
    // disabled codes ignore the lock entirely
    for (int m = 9; m < 16; m++) begin
      wr(OFS_CFG1, 32'(m) << CFG_MODE_LSB);
      lock_pulse();
      rd(OFS_STAT, 32'h0);
      rd(OFS_INT_STAT, 32'h0);
    end
    // interval decode, reserved code included
    wr(OFS_CTRL, 32'h7);
    interval(4'h0);
    interval(4'h1);
    interval(4'h2);
    interval(4'h3);
    interval(4'hF);
    interval(4'h2 + 4'(rnd() % 13));
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule
